// *** bench/spm_master_core_tb.sv ***
// Self-checking bench for the SPI master core
module spm_master_core_tb
	import spm_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} spm_row_type;
	spm_row_type rows [5] = '{'{8'hfc, 8'h7e, 8'h7e}, '{8'hfd, 8'h05, 8'h05}, '{8'hfd, 8'hfa, 8'h0a},
		'{8'h10, 8'h55, 8'h00}, '{8'hfe, 8'h00, 8'h03}};
	logic [2:0] divCode [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h7};
	int halfLen [5] = '{1, 2, 16, 32, 32};
	logic sys_clk, rst_n, sfrWr, sfrRd, sck, mosi, miso, spiIrq, selN, cpol, cpha, lsbFirst, level;
	logic [7:0] sfrAddr, sfrWrData, sfrRdData, slaveTx, slaveRx, got;
	int errCount = 0;
	int cmpCount = 0;
	int n;

	spm_master_core uut (.sys_clk(sys_clk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
		.sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData(sfrRdData), .masterSerialClockPin(sck),
		.masterOutPin(mosi), .masterInPin(miso), .spiIrq(spiIrq));
	spm_slave_model slave (.sck(sck), .mosi(mosi), .selN(selN), .cpol(cpol), .cpha(cpha),
		.lsbFirst(lsbFirst), .txByte(slaveTx), .miso(miso), .rxByte(slaveRx));

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
		cmpCount++;
		if (seen !== exp)
		begin
			errCount++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Strobe lowers one edge after it rose, so calls never collide
	task automatic sfrWrite(input logic [7:0] addr, input logic [7:0] data);
		@(posedge sys_clk);
		sfrAddr <= addr;
		sfrWrData <= data;
		sfrWr <= 1'b1;
		@(posedge sys_clk);
		sfrWr <= 1'b0;
	endtask
	task automatic sfrRead(input logic [7:0] addr, output logic [7:0] data);
		@(posedge sys_clk);
		sfrAddr <= addr;
		sfrRd <= 1'b1;
		@(posedge sys_clk);
		sfrRd <= 1'b0;
		#1;
		data = sfrRdData;
	endtask
	task automatic readCheck(input logic [7:0] addr, input logic [7:0] exp, input string name);
		logic [7:0] d;
		sfrRead(addr, d);
		check(name, exp, d);
	endtask
	// Polls status, bounded so a stuck engine cannot hang the run
	task automatic waitBit(input int b);
		logic [7:0] st;
		int k;
		st = 8'h00;
		k = 0;
		while (st[b] !== 1'b1 && k < 400)
		begin
			sfrRead(ADDR_STATUS, st);
			k++;
		end
		check("status wait", 8'h01, {7'h0, st[b]});
	endtask
	task automatic sckGap(output int c);
		logic s;
		s = sck;
		c = 0;
		while (sck === s && c < 100)
		begin
			@(posedge sys_clk);
			#1;
			c++;
		end
	endtask
	task automatic irqCheck(input logic [7:0] mask, input logic expIrq);
		sfrWrite(ADDR_IRQ_MASK, mask);
		repeat (3) @(posedge sys_clk);
		#1;
		check("interrupt", {7'h0, expIrq}, {7'h0, spiIrq});
	endtask
	task automatic finalReport();
		$display("comparisons %0d mismatches %0d", cmpCount, errCount);
		if (errCount == 0 && cmpCount > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Generous cap: all tests need well under 10000 cycles
	initial
	begin
		repeat (30000) @(posedge sys_clk);
		errCount++;
		finalReport();
	end

	initial
	begin
		{rst_n, sfrWr, sfrRd, cpol, cpha, lsbFirst} = 6'h00;
		{sfrAddr, sfrWrData, slaveTx} = 24'h0;
		selN = 1'b1;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		readCheck(ADDR_CONFIG_MAIN, 8'h02, "config reset");
		readCheck(ADDR_IRQ_MASK, 8'h0f, "mask reset");
		readCheck(ADDR_STATUS, 8'h03, "status reset");
		readCheck(ADDR_DATA, 8'h00, "data reset");
		check("reset pins", 8'h00, {6'h0, sck, spiIrq});
		$display("test reset done");
		for (int i = 0; i < 5; i++)
		begin
			sfrWrite(rows[i].addr, rows[i].wdata);
			readCheck(rows[i].addr, rows[i].exp, "register row");
		end
		$display("test registers done");
		// Every mode and bit order, full duplex against the slave
		for (int m = 0; m < 8; m++)
		begin
			@(posedge sys_clk);
			{lsbFirst, cpol, cpha} <= m[2:0];
			slaveTx <= 8'h96 ^ m[7:0];
			sfrWrite(ADDR_CONFIG_MAIN, {4'h3, m[2:0], 1'b1});
			// Idle clock level moves one edge after the config write; select only once it has settled
			repeat (2) @(posedge sys_clk);
			selN <= 1'b0;
			sfrWrite(ADDR_DATA, 8'h3a + m[7:0]);
			waitBit(BIT_RX_AVAIL);
			readCheck(ADDR_DATA, 8'h96 ^ m[7:0], "rx byte");
			check("slave byte", 8'h3a + m[7:0], slaveRx);
			check("idle clock", {7'h0, m[1]}, {7'h0, sck});
			@(posedge sys_clk);
			selN <= 1'b1;
		end
		$display("test modes done");
		for (int i = 0; i < 5; i++)
		begin
			sfrWrite(ADDR_CONFIG_MAIN, {1'b0, divCode[i], 4'h1});
			sfrWrite(ADDR_DATA, 8'h5a);
			sckGap(n);
			sckGap(n);
			check("half period", halfLen[i][7:0], n[7:0]);
			waitBit(BIT_RX_AVAIL);
			sfrRead(ADDR_DATA, got);
		end
		$display("test divider done");
		// Disable mid-byte freezes the engine
		sfrWrite(ADDR_CONFIG_MAIN, 8'h31);
		sfrWrite(ADDR_DATA, 8'h11);
		sckGap(n);
		sfrWrite(ADDR_CONFIG_MAIN, 8'h30);
		repeat (2) @(posedge sys_clk);
		level = sck;
		repeat (40) @(posedge sys_clk);
		check("frozen clock", {7'h0, level}, {7'h0, sck});
		readCheck(ADDR_STATUS, 8'h03, "frozen status");
		sfrWrite(ADDR_CONFIG_MAIN, 8'h31);
		waitBit(BIT_RX_AVAIL);
		sfrRead(ADDR_DATA, got);
		$display("test disable done");
		sfrWrite(ADDR_CONFIG_MAIN, 8'h30);
		irqCheck(8'h0e, 1'b1);
		irqCheck(8'h0d, 1'b1);
		irqCheck(8'h03, 1'b0);
		sfrWrite(ADDR_DATA, 8'h21);
		sfrWrite(ADDR_DATA, 8'h22);
		sfrWrite(ADDR_DATA, 8'h23);
		readCheck(ADDR_STATUS, 8'h00, "tx full");
		irqCheck(8'h00, 1'b0);
		sfrWrite(ADDR_CONFIG_MAIN, 8'h31);
		waitBit(BIT_RX_FULL);
		readCheck(ADDR_STATUS, 8'h0f, "rx full");
		irqCheck(8'h07, 1'b1);
		irqCheck(8'h0b, 1'b1);
		sfrRead(ADDR_DATA, got);
		irqCheck(8'h07, 1'b0);
		sfrRead(ADDR_DATA, got);
		readCheck(ADDR_DATA, 8'h00, "empty read");
		$display("test interrupts done");
		finalReport();
	end
endmodule

// *** bench/spm_slave_model.sv ***
// Behavioural SPI slave on the far side of the master core
module spm_slave_model
(
	input wire logic sck,
	input wire logic mosi,
	input wire logic selN,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic lsbFirst,
	input wire logic [7:0] txByte,
	output logic miso,
	output logic [7:0] rxByte
);
	timeunit 1ns;
	timeprecision 1ps;
	int outCnt;
	int inCnt;
	// Next reply bit; nothing after the eighth
	task automatic shiftOut();
		if (outCnt < 8)
			miso = lsbFirst ? txByte[outCnt] : txByte[7-outCnt];
		outCnt++;
	endtask
	initial
	begin
		miso = 1'b0;
		rxByte = 8'h00;
	end
	// Phase 0 needs the first bit out before the first edge
	always @(negedge selN)
	begin
		outCnt = 0;
		inCnt = 0;
		if (!cpha)
			shiftOut();
	end
	// A released line must not look like held data
	always @(posedge selN)
		miso = ~miso;
	// Leading edge leaves the idle level; phase picks sample or shift
	always @(sck)
		if (!selN && sck !== 1'bx)
		begin
			if ((sck != cpol) != cpha)
			begin
				if (inCnt < 8)
					rxByte[lsbFirst ? inCnt : 7-inCnt] = mosi;
				inCnt++;
			end
			else
				shiftOut();
		end
endmodule

// *** hw/spm_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides
module spm_fifo
	import spm_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [CW-1:0] count;
	wire push = inValid && inReady;
	wire pop = outValid && outReady;

	// Flags come from the count, so full and empty are exact
	assign inReady = (count != FULL_COUNT);
	assign outValid = (count != '0);
	assign outData = mem[rdPtr];

	// Storage has no reset; only the pointers and count need one
	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem[wrPtr] <= inData;
	end

	// Pointers wrap at DEPTH so any depth works, not only powers of two
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wrPtr <= (wrPtr == LAST_PTR) ? '0 : wrPtr + 1'b1;
			if (pop)
				rdPtr <= (rdPtr == LAST_PTR) ? '0 : rdPtr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule

// *** hw/spm_master_core.sv ***
// SPI master core: configuration registers, data FIFOs, serial engine
module spm_master_core
	import spm_pkg::*;
#(
	parameter int TX_DEPTH = FIFO_DEPTH,
	parameter int RX_DEPTH = FIFO_DEPTH
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrWr,
	input wire logic sfrRd,
	output logic [7:0] sfrRdData,
	output logic masterSerialClockPin,
	output logic masterOutPin,
	input wire logic masterInPin,
	output logic spiIrq
);
	logic [CFG_W-1:0] masterConfigMain;
	logic [MASK_W-1:0] masterIrqMaskConfig;
	spm_state_type state;
	logic [5:0] divCnt;
	logic [3:0] edgeCnt;
	logic [7:0] rxByte;
	logic [7:0] txOutHold;
	logic inSync1;
	logic inSync2;
	logic inSync3;
	logic inBit;

	// Configuration fields
	wire masterCoreOn = masterConfigMain[BIT_CORE_ON];
	wire sampleEdgeSelect = masterConfigMain[BIT_SAMPLE_EDGE];
	wire serialClockIdleLevel = masterConfigMain[BIT_IDLE_LEVEL];
	wire bitOrderSelect = masterConfigMain[BIT_ORDER];
	wire [2:0] serialClockDivider = masterConfigMain[DIV_MSB:DIV_LSB];

	// Register decode
	wire selCfg = (sfrAddr == ADDR_CONFIG_MAIN);
	wire selMask = (sfrAddr == ADDR_IRQ_MASK);
	wire selStatus = (sfrAddr == ADDR_STATUS);
	wire selData = (sfrAddr == ADDR_DATA);

	// FIFO handshakes
	wire [7:0] txOut;
	wire txOutValid;
	wire txInReady;
	wire [7:0] rxOut;
	wire rxOutValid;
	wire rxInReady;
	wire txPush = sfrWr && selData;
	wire rxPop = sfrRd && selData && rxOutValid;

	// Engine decode
	wire stIdle = (state == ST_IDLE);
	wire stShift = (state == ST_SHIFT);
	wire stDone = (state == ST_DONE);
	// A byte starts only when the receive side can take its answer
	wire startXfer = stIdle && masterCoreOn && txOutValid && rxInReady;
	wire rxPush = stDone && masterCoreOn;

	// Half period in processor cycles: codes 5 to 7 share the slowest rate
	wire [2:0] divCode = (serialClockDivider > DIV_CODE_MAX) ? DIV_CODE_MAX : serialClockDivider;
	wire [5:0] halfLen = 6'(6'h01 << divCode);
	wire divTick = stShift && masterCoreOn && (divCnt == halfLen - 6'h01);

	// Edge bookkeeping: even edges lead, odd edges trail
	wire leadingEdge = !edgeCnt[0];
	wire [2:0] bitNum = edgeCnt[3:1];
	wire [2:0] nextNum = bitNum + 3'h1;
	wire sampleNow = leadingEdge ^ sampleEdgeSelect;
	wire [2:0] curPos = bitOrderSelect ? bitNum : 3'h7 - bitNum;
	wire [2:0] nextPos = bitOrderSelect ? nextNum : 3'h7 - nextNum;
	wire [2:0] firstPos = bitOrderSelect ? 3'h0 : 3'h7;
	wire lastEdge = (edgeCnt == 4'(EDGES_PER_BYTE - 5'h01));

	// Status flags are live views of the FIFOs
	wire [3:0] status = {!rxInReady, rxOutValid, !txOutValid, txInReady};
	wire [3:0] irqActive = status & ~masterIrqMaskConfig;

	wire [7:0] readMux = selCfg ? {1'b0, masterConfigMain} :
		selMask ? {4'h0, masterIrqMaskConfig} :
		selStatus ? {4'h0, status} :
		(selData && rxOutValid) ? rxOut : 8'h00;

	// Transmit FIFO: a write while full is dropped, shown by status bit 0
	spm_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(TX_DEPTH)
	) txFifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.inData(sfrWrData),
		.inValid(txPush),
		.inReady(txInReady),
		.outData(txOut),
		.outValid(txOutValid),
		.outReady(startXfer)
	);

	// Receive FIFO: when full it holds the engine back from the next byte
	spm_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(RX_DEPTH)
	) rxFifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.inData(rxByte),
		.inValid(rxPush),
		.inReady(rxInReady),
		.outData(rxOut),
		.outValid(rxOutValid),
		.outReady(rxPop)
	);

	// Configuration writes and registered read data
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			masterConfigMain <= CFG_RESET;
			masterIrqMaskConfig <= MASK_RESET;
			sfrRdData <= RDATA_RESET;
		end
		else
		begin
			if (sfrWr && selCfg)
				masterConfigMain <= sfrWrData[CFG_W-1:0];
			if (sfrWr && selMask)
				masterIrqMaskConfig <= sfrWrData[MASK_W-1:0];
			if (sfrRd)
				sfrRdData <= readMux;
		end
	end

	// Interrupt line is a registered level that drops one cycle after its cause goes away
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			spiIrq <= 1'b0;
		else
			spiIrq <= |irqActive;
	end

	// Input pin synchroniser; a change counts once stages two and three agree
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			inSync1 <= 1'b0;
			inSync2 <= 1'b0;
			inSync3 <= 1'b0;
			inBit <= 1'b0;
		end
		else
		begin
			inSync1 <= masterInPin;
			inSync2 <= inSync1;
			inSync3 <= inSync2;
			if (inSync2 == inSync3)
				inBit <= inSync3;
		end
	end

	// Transfer engine; everything but the idle clock level freezes while off
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			divCnt <= '0;
			edgeCnt <= '0;
			rxByte <= '0;
			masterSerialClockPin <= 1'b0;
			masterOutPin <= 1'b0;
		end
		else
		begin
			if (stIdle)
				masterSerialClockPin <= serialClockIdleLevel;
			if (masterCoreOn)
			begin
				case (state)
					ST_IDLE:
					begin
						if (startXfer)
						begin
							state <= ST_SHIFT;
							divCnt <= '0;
							edgeCnt <= '0;
							rxByte <= '0;
							if (!sampleEdgeSelect)
								masterOutPin <= txOut[firstPos];
						end
					end
					ST_SHIFT:
					begin
						if (divTick)
						begin
							divCnt <= '0;
							masterSerialClockPin <= !masterSerialClockPin;
							edgeCnt <= edgeCnt + 4'h1;
							if (sampleNow)
								rxByte[curPos] <= inBit;
							if (sampleEdgeSelect && leadingEdge)
								masterOutPin <= txOutHold[curPos];
							if (!sampleEdgeSelect && !leadingEdge && bitNum != 3'h7)
								masterOutPin <= txOutHold[nextPos];
							if (lastEdge)
								state <= ST_DONE;
						end
						else
							divCnt <= divCnt + 6'h01;
					end
					ST_DONE:
						state <= ST_IDLE;
					default:
						state <= ST_IDLE;
				endcase
			end
		end
	end

	// The byte in flight is held here since the FIFO entry is freed at start
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			txOutHold <= '0;
		else if (startXfer)
			txOutHold <= txOut;
	end

	// Checking helpers: clock edges counted since the start of a byte
	logic [4:0] edgeTotal;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			edgeTotal <= '0;
		else if (startXfer)
			edgeTotal <= '0;
		else if (divTick)
			edgeTotal <= edgeTotal + 5'h01;
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	sequence seqStartMode0;
		startXfer && !sampleEdgeSelect;
	endsequence

	sequence seqSettledIdle;
		stIdle ##1 stIdle;
	endsequence

	a_idle_clock_level: assert property (seqSettledIdle |-> masterSerialClockPin == $past(serialClockIdleLevel))
		else $error("serial clock not at idle level between transfers");

	a_first_bit_out: assert property (seqStartMode0 |=> masterOutPin == $past(txOut[firstPos]))
		else $error("first data bit not presented at transfer start");

	a_byte_edges: assert property (rxPush |-> edgeTotal == EDGES_PER_BYTE)
		else $error("received byte stored after wrong number of clock edges");

	a_core_frozen: assert property (!masterCoreOn |=> $stable(state) && $stable(edgeCnt) && $stable(rxByte))
		else $error("engine moved while the core is off");

	a_start_needs_data: assert property (stShift && !$past(stShift) |-> $past(txOutValid && masterCoreOn))
		else $error("transfer began without enable or data");

	a_rx_full_irq: assert property (!rxInReady && !masterIrqMaskConfig[BIT_RX_FULL] |=> spiIrq)
		else $error("unmasked receive full did not raise interrupt");

	a_rx_avail_irq: assert property (rxOutValid && !masterIrqMaskConfig[BIT_RX_AVAIL] |=> spiIrq)
		else $error("unmasked receive data did not raise interrupt");

	a_tx_empty_irq: assert property (!txOutValid && !masterIrqMaskConfig[BIT_TX_EMPTY] |=> spiIrq)
		else $error("unmasked transmit empty did not raise interrupt");

	a_tx_space_irq: assert property (txInReady && !masterIrqMaskConfig[BIT_TX_SPACE] |=> spiIrq)
		else $error("unmasked transmit space did not raise interrupt");

	a_irq_all_masked: assert property ((status & ~masterIrqMaskConfig) == 4'h0 |=> !spiIrq)
		else $error("interrupt raised with every active source masked");
endmodule

// *** hw/spm_pkg.sv ***
// Shared register map, field layout and reset values of the SPI master core
package spm_pkg;
	// Register addresses on the special-function-register bus
	localparam logic [7:0] ADDR_CONFIG_MAIN = 8'hfc;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'hfd;
	localparam logic [7:0] ADDR_STATUS = 8'hfe;
	localparam logic [7:0] ADDR_DATA = 8'hff;

	// Widths of the configuration registers and of the data path
	localparam int CFG_W = 7;
	localparam int MASK_W = 4;
	localparam int DATA_W = 8;

	// Reset values
	localparam logic [6:0] CFG_RESET = 7'h02;
	localparam logic [3:0] MASK_RESET = 4'hf;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	// Fields of master_config_main
	localparam int BIT_CORE_ON = 0;
	localparam int BIT_SAMPLE_EDGE = 1;
	localparam int BIT_IDLE_LEVEL = 2;
	localparam int BIT_ORDER = 3;
	localparam int DIV_LSB = 4;
	localparam int DIV_MSB = 6;

	// Fields of master_irq_mask_config and of the status register
	localparam int BIT_RX_FULL = 3;
	localparam int BIT_RX_AVAIL = 2;
	localparam int BIT_TX_EMPTY = 1;
	localparam int BIT_TX_SPACE = 0;

	// Divider codes from this one upward all give the slowest rate
	localparam logic [2:0] DIV_CODE_MAX = 3'h5;
	// Serial clock edges in one byte (two per bit)
	localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
	// Depth of each data FIFO
	localparam int FIFO_DEPTH = 2;

	// Transfer engine states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SHIFT = 3'b010,
		ST_DONE = 3'b100
	} spm_state_type;
endpackage
